/* File: verilog/rcw_top.sv */
// Reset control unit with watchdog, flags and an AXI4-Lite register slave.
module rcw_top
   import rcw_pkg::*;
#(
   parameter int unsigned POR_COUNT = POR_DELAY_CLOCKS,
   parameter int unsigned DOG_COUNT = DOG_MAIN_COUNT
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [31:0] araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        reset_pin_n,
   input  wire logic        power_low,
   input  wire logic        long_delay_active,
   input  wire logic        low_voltage_detect,
   input  wire logic        cpu_idle,
   output logic             sys_reset_n
);

   // ---------------- AXI4-Lite slave ----------------
   logic          aw_full, next_aw_full, w_full, next_w_full;
   logic [31:0]   aw_addr, next_aw_addr;
   logic [7:0]    w_data, next_w_data;
   logic          w_lane0, next_w_lane0;
   logic          next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]    next_bresp, next_rresp;
   logic [31:0]   next_rdata;
   logic          do_write;
   rcw_reg_t      wr_sel, rd_sel;

   // Block state; the watchdog control and both flags are read back over the bus, the reset state is not.
   rcw_dog_ctrl_t ctrl, next_ctrl;
   logic          power_on_flag, next_power_on_flag, low_voltage_flag, next_low_voltage_flag;
   rcw_state_t    state, next_state;

   assign do_write = aw_full && w_full && !bvalid;
   assign wr_sel   = rcw_decode(aw_addr);
   assign rd_sel   = rcw_decode(araddr);

   always_comb begin
      next_aw_full = aw_full;
      next_aw_addr = aw_addr;
      next_w_full  = w_full;
      next_w_data  = w_data;
      next_w_lane0 = w_lane0;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (awvalid && awready) begin
         next_aw_full = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_full  = 1'b1;
         next_w_data  = wdata[7:0];
         next_w_lane0 = wstrb[0];
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         case (rd_sel)
            REG_WDC: next_rdata = {24'h0, ctrl.flag, 1'b0, ctrl.enable, 1'b0, // R9 R18
                                   ctrl.run_in_idle, ctrl.prescale_sel};
            REG_PC:  next_rdata = {26'h0, low_voltage_flag, power_on_flag, 4'h0};
            REG_PGC: next_rdata = 32'h0; // R16
            default: begin
               next_rdata = 32'h0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
      next_awready = !next_aw_full;
      next_wready  = !next_w_full;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= 32'h0;
         w_full  <= 1'b0;
         w_data  <= 8'h0;
         w_lane0 <= 1'b0;
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= RESP_OKAY;
      end else begin
         aw_full <= next_aw_full;
         aw_addr <= next_aw_addr;
         w_full  <= next_w_full;
         w_data  <= next_w_data;
         w_lane0 <= next_w_lane0;
         awready <= next_awready;
         wready  <= next_wready;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // ---------------- Register writes and flags ----------------
   logic wr_wdc, wr_pc, kick, soft_req, dog_overflow;

   // Writes without the low byte lane answer OKAY but change nothing.
   assign wr_wdc   = do_write && w_lane0 && wr_sel == REG_WDC;
   assign wr_pc    = do_write && w_lane0 && wr_sel == REG_PC;
   assign kick     = wr_wdc && w_data[WDC_KICK_BIT]; // R9
   assign soft_req = do_write && w_lane0 && wr_sel == REG_PGC && w_data[PGC_SOFT_BIT]; // R16

   always_comb begin
      next_ctrl = ctrl;
      next_power_on_flag    = power_on_flag;
      next_low_voltage_flag = low_voltage_flag;
      if (wr_wdc) begin
         next_ctrl.enable       = w_data[5]; // R8
         next_ctrl.run_in_idle  = w_data[3]; // R12
         next_ctrl.prescale_sel = w_data[2:0]; // R13
         if (!w_data[WDC_FLAG_BIT]) next_ctrl.flag = 1'b0;
      end
      next_ctrl.kick = 1'b0; // R9
      next_ctrl.rsvd = 1'b0; // R18
      // A reset in progress returns the watchdog settings to idle but keeps its flag.
      if (state != ST_RUN) begin
         next_ctrl.enable       = 1'b0;
         next_ctrl.run_in_idle  = 1'b0;
         next_ctrl.prescale_sel = 3'h0;
      end
      if (dog_overflow) next_ctrl.flag = 1'b1; // R11
      if (wr_pc && !w_data[PC_POWER_ON_BIT]) next_power_on_flag = 1'b0;
      if (wr_pc && !w_data[PC_LVD_BIT]) next_low_voltage_flag = 1'b0;
      if (power_low) next_power_on_flag = 1'b1; // R5
      if (low_voltage_detect) next_low_voltage_flag = 1'b1; // R6
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= WDC_RESET;
         power_on_flag    <= POWER_ON_FLAG_RESET;
         low_voltage_flag <= LOW_VOLTAGE_FLAG_RESET;
      end else begin
         ctrl <= next_ctrl;
         power_on_flag    <= next_power_on_flag;
         low_voltage_flag <= next_low_voltage_flag;
      end
   end

   // ---------------- Watchdog counters ----------------
   logic [3:0]  div12, next_div12;
   logic [7:0]  pre_cnt, next_pre_cnt;
   logic [14:0] dog_cnt, next_dog_cnt;
   logic        cnt_en, div_tick, pre_tick, main_last;

   assign cnt_en    = state == ST_RUN && ctrl.enable && (!cpu_idle || ctrl.run_in_idle) && !kick; // R8 R12
   assign div_tick  = div12 == DOG_DIV12_LAST; // R14
   assign pre_tick  = pre_cnt == rcw_ps_last(ctrl.prescale_sel); // R13
   assign main_last = dog_cnt == 15'(DOG_COUNT - 1);
   assign dog_overflow = cnt_en && div_tick && pre_tick && main_last; // R7 R10

   always_comb begin
      next_div12   = div12;
      next_pre_cnt = pre_cnt;
      next_dog_cnt = dog_cnt;
      if (state != ST_RUN || kick) begin
         next_div12   = 4'h0; // R9
         next_pre_cnt = 8'h0;
         next_dog_cnt = 15'h0;
      end else if (cnt_en) begin
         next_div12 = div_tick ? 4'h0 : div12 + 4'h1;
         if (div_tick) begin
            next_pre_cnt = pre_tick ? 8'h0 : pre_cnt + 8'h1; // R7
            if (pre_tick) next_dog_cnt = main_last ? 15'h0 : dog_cnt + 15'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div12   <= 4'h0;
         pre_cnt <= 8'h0;
         dog_cnt <= 15'h0;
      end else begin
         div12   <= next_div12;
         pre_cnt <= next_pre_cnt;
         dog_cnt <= next_dog_cnt;
      end
   end

   // ---------------- Reset merge ----------------
   logic        pin_level, level_src, pulse_src, next_sys_reset_n;
   logic [15:0] por_cnt, next_por_cnt;
   logic [2:0]  stretch, next_stretch;

   rcw_pin_filter u_pin_filter (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_in    (reset_pin_n),
      .pin_level (pin_level)
   );

   assign level_src = !pin_level || long_delay_active || low_voltage_detect; // R1
   // One-cycle sources are stretched so that every consumer sees the reset.
   assign pulse_src = dog_overflow || soft_req; // R1 R10 R16

   always_comb begin
      next_state   = state;
      next_por_cnt = por_cnt;
      next_stretch = stretch;
      case (state)
         ST_POR: begin
            if (por_cnt == 16'(POR_COUNT - 1)) begin
               next_state   = level_src ? ST_HOLD : ST_RUN; // R4
               next_stretch = RESET_PULSE_LAST;
            end else begin
               next_por_cnt = por_cnt + 16'h1;
            end
         end
         ST_HOLD: begin
            if (level_src || pulse_src) next_stretch = RESET_PULSE_LAST;
            else if (stretch == 3'h0) next_state = ST_RUN;
            else next_stretch = stretch - 3'h1;
         end
         ST_RUN: begin
            if (level_src || pulse_src) begin
               next_state   = ST_HOLD;
               next_stretch = RESET_PULSE_LAST;
            end
         end
         default: next_state = ST_POR;
      endcase
      if (power_low) begin
         next_state   = ST_POR; // R4
         next_por_cnt = 16'h0;
      end
      next_sys_reset_n = next_state == ST_RUN; // R17
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state       <= ST_POR;
         por_cnt     <= 16'h0;
         stretch     <= 3'h0;
         sys_reset_n <= 1'b0;
      end else begin
         state       <= next_state;
         por_cnt     <= next_por_cnt;
         stretch     <= next_stretch;
         sys_reset_n <= next_sys_reset_n;
      end
   end

   // ---------------- Assertions ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_reset_stretch;
      !sys_reset_n [*4];
   endsequence

   sequence s_counters_zero;
      div12 == 4'h0 && pre_cnt == 8'h0 && dog_cnt == 15'h0;
   endsequence

   a_kick_restart: assert property (kick |=> s_counters_zero) // R9
      else $error("kick did not restart the watchdog");
   a_dog_reset_out: assert property (dog_overflow |=> s_reset_stretch) // R10
      else $error("watchdog overflow did not hold reset");
   a_dog_flag_set: assert property (dog_overflow |=> ctrl.flag ##1 ctrl.flag) // R11
      else $error("watchdog flag not set by overflow");
   a_soft_reset_out: assert property (soft_req |=> s_reset_stretch) // R16
      else $error("software request did not hold reset");
   a_power_flag_set: assert property (power_low |=> power_on_flag && !sys_reset_n) // R4 R5
      else $error("power loss did not set flag and reset");
   a_lvd_flag_set: assert property (low_voltage_detect |=> low_voltage_flag) // R6
      else $error("low voltage flag not set");
   a_idle_suspend: assert property (state == ST_RUN && cpu_idle && !ctrl.run_in_idle && !kick |=> $stable(div12)) // R12
      else $error("watchdog counted during idle");
   a_por_release: assert property (state == ST_POR && por_cnt == 16'(POR_COUNT - 1) && !power_low
                                   && !level_src |=> sys_reset_n) // R4 R17
      else $error("power-on delay did not release reset");
   a_rsvd_reads_zero: assert property ($rose(rvalid) && $past(rd_sel) == REG_WDC |-> !rdata[6]) // R18
      else $error("reserved watchdog bit read as one");
   a_prescale_wrap: assert property (cnt_en && div_tick && pre_tick |=> pre_cnt == 8'h0 && div12 == 4'h0) // R13
      else $error("prescaler did not wrap at selected value");
   a_disable_stops: assert property (state == ST_RUN && !ctrl.enable && !kick |=> $stable(dog_cnt)) // R8
      else $error("disabled watchdog kept counting");

endmodule

/* File: verilog/rcw_pkg.sv */
// Constants, types and helpers shared by the reset control and watchdog block.
// Behaviour
// R1: Six sources drive one internal reset: pin, power-on, watchdog, software, long delay, low voltage.
// R2: The outside party holds each reset pin level change 24 clocks plus 10 us.
// R3: Above 12 MHz the system should also use the secondary reset input; the block has only reset_pin_n, with a 25 ns clock.
// R4: Supply low holds reset; release follows automatically 32768 clocks after power returns.
// R5: power_on_flag (power control bit 4) sets on power-on; only software clears it.
// R6: low_voltage_flag (power control bit 5) sets on low voltage; software clears it.
// R7: Watchdog is an 8-bit prescaler feeding a 15-bit counter; counter overflow is timeout.
// R8: dog_enable (watchdog control bit 5) starts counting; clearing it stops counting.
// R9: Writing 1 to dog_kick (bit 4) restarts counting from zero; bit reads zero.
// R10: Overflow of the enabled watchdog raises an internal system reset.
// R11: Overflow sets dog_reset_flag (bit 7), which survives reset; only software clears it. Here aresetn also clears it.
// R12: dog_run_in_idle (bit 3) keeps counting in idle; clear suspends counting in idle.
// R13: dog_prescale_sel (bits 2..0) selects prescale of two to the power field plus one.
// R14: Timeout is 12 times prescale times 32768 clocks, via a divide-by-12 stage.
// R15: Software must kick the enabled watchdog before each timeout expires.
// R16: Writing 1 to soft_reset_trigger (programming control bit 5) resets; bit self-clears.
// R17: All sources merge into one reset whose release is synchronous to the clock.
// R18: Watchdog control bit 6 is reserved: writes ignored, reads zero.
package rcw_pkg;

   localparam int unsigned CLK_PERIOD_NS        = 25;
   localparam int unsigned PIN_HOLD_BASE_CYCLES = 24;
   localparam int unsigned PIN_HOLD_NS          = 10000;
   localparam int unsigned PIN_HOLD_CYCLES      = PIN_HOLD_BASE_CYCLES
                                                  + (PIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PIN_CNT_W            = 10;

   localparam int unsigned POR_DELAY_CLOCKS     = 32768;
   localparam int unsigned DOG_MAIN_COUNT       = 32768;
   localparam logic [3:0]  DOG_DIV12_LAST       = 4'hb;
   localparam logic [2:0]  RESET_PULSE_LAST     = 3'h3;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0]  IDX_WATCHDOG_CONTROL    = 8'hc1;
   localparam logic [7:0]  IDX_POWER_CONTROL       = 8'hc2;
   localparam logic [7:0]  IDX_PROGRAMMING_CONTROL = 8'hc3;

   localparam int unsigned WDC_FLAG_BIT      = 7;
   localparam int unsigned WDC_KICK_BIT      = 4;
   localparam int unsigned PC_LVD_BIT        = 5;
   localparam int unsigned PC_POWER_ON_BIT   = 4;
   localparam int unsigned PGC_SOFT_BIT      = 5;

   localparam logic        POWER_ON_FLAG_RESET    = 1'b1;
   localparam logic        LOW_VOLTAGE_FLAG_RESET = 1'b1;

   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   typedef struct packed {
      logic       flag;
      logic       rsvd;
      logic       enable;
      logic       kick;
      logic       run_in_idle;
      logic [2:0] prescale_sel;
   } rcw_dog_ctrl_t;

   localparam rcw_dog_ctrl_t WDC_RESET = 8'h00;

   typedef enum logic [2:0] {
      ST_POR  = 3'h1,
      ST_HOLD = 3'h2,
      ST_RUN  = 3'h4
   } rcw_state_t;

   typedef enum logic [1:0] {
      REG_WDC  = 2'h0,
      REG_PC   = 2'h1,
      REG_PGC  = 2'h2,
      REG_NONE = 2'h3
   } rcw_reg_t;

   function automatic rcw_reg_t rcw_decode(input logic [31:0] addr);
      rcw_reg_t r;
      r = REG_NONE;
      if (addr[1:0] == 2'h0 && addr[31:10] == 22'h0) begin
         if (addr[9:2] == IDX_WATCHDOG_CONTROL) r = REG_WDC;
         else if (addr[9:2] == IDX_POWER_CONTROL) r = REG_PC;
         else if (addr[9:2] == IDX_PROGRAMMING_CONTROL) r = REG_PGC;
      end
      return r;
   endfunction

   function automatic logic [7:0] rcw_ps_last(input logic [2:0] sel);
      logic [8:0] v;
      v = (9'h2 << sel) - 9'h1;
      return v[7:0];
   endfunction

endpackage

/* File: verilog/rcw_pin_filter.sv */
// Stability filter that accepts a reset pin level only after it has been held long enough.
module rcw_pin_filter
   import rcw_pkg::*;
#(
   parameter int unsigned STABLE_CYCLES = PIN_HOLD_CYCLES
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_in,
   output logic      pin_level
);

   logic [PIN_CNT_W-1:0] cnt;
   logic [PIN_CNT_W-1:0] next_cnt;
   logic                 next_pin_level;

   // Short glitches restart the count, so only a level held the full time passes.
   always_comb begin
      next_cnt       = '0;
      next_pin_level = pin_level;
      if (pin_in != pin_level) begin
         if (cnt == PIN_CNT_W'(STABLE_CYCLES - 1)) begin
            next_pin_level = pin_in; // R2
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt       <= '0;
         pin_level <= 1'b1;
      end else begin
         cnt       <= next_cnt;
         pin_level <= next_pin_level;
      end
   end

endmodule

/* File: tb/rcw_top_tb.sv */
// Self-checking bench for the reset control and watchdog block.
module rcw_top_tb;
   import rcw_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // Short counts keep the run brief; the timeout and power-on waits below derive from these.
   localparam int unsigned POR_SIM = 16;
   localparam int unsigned DOG_SIM = 4;
   localparam logic [31:0] A_WDC   = {22'h0, IDX_WATCHDOG_CONTROL, 2'h0};
   localparam logic [31:0] A_PC    = {22'h0, IDX_POWER_CONTROL, 2'h0};
   localparam logic [31:0] A_PGC   = {22'h0, IDX_PROGRAMMING_CONTROL, 2'h0};

   logic        aclk = 1'b0;
   logic        aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, b_seen;
   logic        reset_pin_n, power_low, long_delay_active, low_voltage_detect, cpu_idle, sys_reset_n;
   int          bad_count, n_checks, n;

   always #12.5 aclk = ~aclk;

   rcw_top #(.POR_COUNT(POR_SIM), .DOG_COUNT(DOG_SIM)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .reset_pin_n(reset_pin_n), .power_low(power_low),
      .long_delay_active(long_delay_active), .low_voltage_detect(low_voltage_detect), .cpu_idle(cpu_idle),
      .sys_reset_n(sys_reset_n));

   task automatic complete_run();
      $display("Mismatches %0d, comparisons %0d", bad_count, n_checks);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic give_up();
      bad_count++;
      $display("Error at %0t ns: wait ran out", $time);
      complete_run();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic sys_is(input logic e);
      check({31'h0, sys_reset_n}, {31'h0, e});
   endtask

   // Counts edges until the merged reset shows the wanted level.
   task automatic wait_rst(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (sys_reset_n !== lvl) begin
         @(posedge aclk);
         cnt++;
         if (cnt > lim) give_up();
      end
   endtask

   // Address and data are offered together; each is dropped at its own handshake.
   task automatic axw(input logic [31:0] a, input logic [7:0] d);
      logic ad;
      logic wd;
      int   k;
      ad = 1'b0;
      wd = 1'b0;
      k = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         k++;
         if (!ad && awready === 1'b1) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
         if (k > 50) give_up();
      end
      while (bvalid !== 1'b1) begin
         @(posedge aclk);
         k++;
         if (k > 100) give_up();
      end
      // Response readies stay high, so back-to-back calls never drive them twice in one step.
      b_seen = bresp;
   endtask

   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (k > 50) give_up();
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         k++;
         if (k > 100) give_up();
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axr(a, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   task automatic t_registers();
      logic [31:0] d;
      logic [1:0]  r;
      rd_chk(A_WDC, 32'h00);
      rd_chk(A_PC, 32'h30);
      axw(A_WDC, 8'h4b);
      check({30'h0, b_seen}, {30'h0, RESP_OKAY});
      rd_chk(A_WDC, 32'h0b);
      axw(A_WDC, 8'h13);
      rd_chk(A_WDC, 32'h03);
      wstrb <= 4'h0;
      axw(A_WDC, 8'h07);
      wstrb <= 4'hf;
      rd_chk(A_WDC, 32'h03);
      axw(A_WDC, 8'h00);
      axr(32'h400, d, r);
      check(d, 32'h0);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      axw(32'h400, 8'h3f);
      check({30'h0, b_seen}, {30'h0, RESP_SLVERR});
      rd_chk(A_WDC, 32'h00);
   endtask

   // Every prescale code: no reset just before the period, reset just after it.
   task automatic t_timeout();
      for (int s = 0; s < 8; s++) begin
         axw(A_WDC, {5'h04, s[2:0]});
         repeat (((12 * DOG_SIM) << (s + 1)) - 8) @(posedge aclk);
         sys_is(1'b1);
         wait_rst(1'b0, 24, n);
         wait_rst(1'b1, 40, n);
         rd_chk(A_WDC, 32'h80);
         axw(A_WDC, 8'h80);
         rd_chk(A_WDC, 32'h80);
         axw(A_WDC, 8'h00);
         rd_chk(A_WDC, 32'h00);
      end
   endtask

   task automatic t_kick_and_stop();
      axw(A_WDC, 8'h20);
      repeat (5) begin
         repeat (60) @(posedge aclk);
         axw(A_WDC, 8'h30);
      end
      sys_is(1'b1);
      axw(A_WDC, 8'h00);
      repeat (200) @(posedge aclk);
      sys_is(1'b1);
   endtask

   task automatic t_idle();
      cpu_idle <= 1'b1;
      axw(A_WDC, 8'h20);
      repeat (200) @(posedge aclk);
      sys_is(1'b1);
      axw(A_WDC, 8'h28);
      wait_rst(1'b0, 120, n);
      cpu_idle <= 1'b0;
      wait_rst(1'b1, 40, n);
      axw(A_WDC, 8'h00);
   endtask

   task automatic t_soft();
      axw(A_PC, 8'h00);
      rd_chk(A_PC, 32'h00);
      axw(A_PGC, 8'h20);
      wait_rst(1'b0, 8, n);
      wait_rst(1'b1, 40, n);
      rd_chk(A_PGC, 32'h00);
      rd_chk(A_PC, 32'h00);
   endtask

   task automatic t_sources();
      low_voltage_detect <= 1'b1;
      repeat (3) @(posedge aclk);
      sys_is(1'b0);
      low_voltage_detect <= 1'b0;
      wait_rst(1'b1, 40, n);
      rd_chk(A_PC, 32'h20);
      axw(A_PC, 8'h00);
      long_delay_active <= 1'b1;
      repeat (3) @(posedge aclk);
      sys_is(1'b0);
      long_delay_active <= 1'b0;
      wait_rst(1'b1, 40, n);
      reset_pin_n <= 1'b0;
      repeat (200) @(posedge aclk);
      reset_pin_n <= 1'b1;
      repeat (PIN_HOLD_CYCLES + 10) @(posedge aclk);
      sys_is(1'b1);
      reset_pin_n <= 1'b0;
      wait_rst(1'b0, PIN_HOLD_CYCLES + 8, n);
      check({31'h0, n >= PIN_HOLD_CYCLES - 2}, 32'h1);
      reset_pin_n <= 1'b1;
      wait_rst(1'b1, PIN_HOLD_CYCLES + 40, n);
   endtask

   task automatic t_power();
      logic [31:0] d;
      logic [1:0]  r;
      axw(A_PC, 8'h00);
      power_low <= 1'b1;
      repeat (100) @(posedge aclk);
      sys_is(1'b0);
      power_low <= 1'b0;
      wait_rst(1'b1, POR_SIM + 12, n);
      check({31'h0, n >= POR_SIM}, 32'h1);
      axr(A_PC, d, r);
      check(d & 32'h10, 32'h10);
   endtask

   initial begin
      bad_count = 0;
      n_checks = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
      wstrb = 4'hf;
      reset_pin_n = 1'b1;
      {power_low, long_delay_active, low_voltage_detect, cpu_idle} = 4'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wait_rst(1'b1, POR_SIM + 20, n);
      t_registers();
      t_timeout();
      t_kick_and_stop();
      t_idle();
      t_soft();
      t_sources();
      t_power();
      complete_run();
   end
endmodule
